/* File: design/ccd_cfg.svh */
// Purpose: constants for the clear/complement/decrement execution block
// Assumes: 14-bit opcodes, 8-bit data, 7-bit file addresses
// Notes: included by the core only; the package does not include it
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH
// ----------------------------------------
// Opcode encodings
// ----------------------------------------
`define CCD_OPC_ZERO_ACC 14'h0103
`define CCD_OPC_WDOG_KICK 14'h0064
`define CCD_OPC_DEC_HI 6'h03
`define CCD_OPC_INV_HI 6'h09
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCD_DEST_BIT 7
`define CCD_ADDR_MSB 6
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CCD_WDOG_RST 8'h00
`define CCD_PRESC_RST 8'h00
`define CCD_ACC_RST 8'h00
`define CCD_Q_PER_CYCLE 4
`define CCD_Q_CNT_RST 2'h0
`endif

/* File: design/ccd_exec.sv */
// Purpose: execute zero_accumulator_op, invert_file_op, watchdog_kick_op, decrement_file_op
// Assumes: file read data for opcode address is valid while instr_valid_i is high
// Notes: one instruction per four-phase cycle; results commit on the last phase
`timescale 1ns/10ps
`default_nettype none
`include "ccd_cfg.svh"

module ccd_exec #(
  parameter int WDOG_W = 8,
  parameter int PRESC_W = 8
) (
  input wire logic sys_clk_i, // 10 MHz oscillator clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic clk_en_i, // Freezes all state when low
  input wire logic instr_valid_i, // Opcode valid this cycle
  input wire logic [13:0] instr_i, // Opcode word
  input wire logic [7:0] file_rdata_i, // Addressed file register contents
  input wire logic presc_to_wdog_i, // Prescaler assigned to watchdog
  input wire logic wdog_tick_i, // Watchdog count source pulse
  input wire logic status_set_i, // Load status flags from outside
  input wire ccd_pkg::ccd_stat_s status_in_i, // Status values to load
  output logic [6:0] file_addr_o, // File address being read
  output ccd_pkg::ccd_fwr_s file_wr_o, // File write strobe/address/data
  output logic [7:0] acc_o, // Working register
  output ccd_pkg::ccd_stat_s status_o, // Zero, expiry_n, sleep_n flags
  output logic [WDOG_W-1:0] watchdog_counter_o, // Watchdog count
  output logic [PRESC_W-1:0] presc_o, // Shared prescaler count
  output logic instr_done_o // Pulse in the cycle after the commit phase
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic ccd_pkg::ccd_op_e decode(input logic [13:0] op);
    if (op == `CCD_OPC_ZERO_ACC)
      return ccd_pkg::CCD_OP_ZERO_ACC;
    else if (op == `CCD_OPC_WDOG_KICK)
      return ccd_pkg::CCD_OP_WDOG;
    else if (op[13:8] == `CCD_OPC_DEC_HI)
      return ccd_pkg::CCD_OP_DEC;
    else if (op[13:8] == `CCD_OPC_INV_HI)
      return ccd_pkg::CCD_OP_INV;
    else
      return ccd_pkg::CCD_OP_NONE;
  endfunction : decode

  ccd_pkg::ccd_op_e op_w;
  assign op_w = decode(instr_i);
  assign file_addr_o = instr_i[`CCD_ADDR_MSB:0];

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  logic [1:0] q_cnt_q;
  logic [1:0] q_cnt_d;
  logic commit_w;

  always_comb
  begin
    q_cnt_d = q_cnt_q + 2'h1;
  end
  assign commit_w = (q_cnt_q == 2'(`CCD_Q_PER_CYCLE - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_cnt_q <= `CCD_Q_CNT_RST;
    else if (clk_en_i)
      q_cnt_q <= q_cnt_d;
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  ccd_pkg::ccd_stat_s stat_q;
  ccd_pkg::ccd_stat_s stat_d;
  ccd_pkg::ccd_fwr_s fwr_q;
  ccd_pkg::ccd_fwr_s fwr_d;
  logic [WDOG_W-1:0] wdog_q;
  logic [WDOG_W-1:0] wdog_d;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic done_q;
  logic done_d;
  logic [7:0] res;
  logic go;
  logic kick;

  always_comb
  begin
    acc_d = acc_q;
    stat_d = stat_q;
    fwr_d = fwr_q;
    fwr_d.we = 1'b0;
    wdog_d = wdog_q;
    presc_d = presc_q;
    res = 8'h00;
    go = instr_valid_i && commit_w;
    kick = go && (op_w == ccd_pkg::CCD_OP_WDOG);
    done_d = go;
    if (status_set_i)
      stat_d = status_in_i;
    // Prescaler feeds the watchdog only when assigned to it
    if (wdog_tick_i)
    begin
      if (presc_to_wdog_i)
      begin
        presc_d = presc_q + PRESC_W'(1);
        if (presc_q == {PRESC_W{1'b1}})
          wdog_d = wdog_q + WDOG_W'(1);
      end
      else
        wdog_d = wdog_q + WDOG_W'(1);
    end
    if (go)
    begin
      case (op_w)
        ccd_pkg::CCD_OP_ZERO_ACC:
        begin
          acc_d = `CCD_ACC_RST;
          stat_d.zero = 1'b1;
        end
        ccd_pkg::CCD_OP_INV, ccd_pkg::CCD_OP_DEC:
        begin
          if (op_w == ccd_pkg::CCD_OP_INV)
            res = ~file_rdata_i;
          else
            res = file_rdata_i - 8'h01;
          stat_d.zero = (res == 8'h00);
          if (instr_i[`CCD_DEST_BIT])
          begin
            fwr_d.we = 1'b1;
            fwr_d.addr = instr_i[`CCD_ADDR_MSB:0];
            fwr_d.data = res;
          end
          else
            acc_d = res;
        end
        ccd_pkg::CCD_OP_WDOG:
        begin
          stat_d.wdog_expiry_flag_n = 1'b1;
          stat_d.sleep_entered_flag_n = 1'b1;
        end
        default:
        begin
          acc_d = acc_q;
        end
      endcase
    end
    // Kick overrides any tick landing in the same cycle
    if (kick)
    begin
      wdog_d = WDOG_W'(`CCD_WDOG_RST);
      if (presc_to_wdog_i)
        presc_d = PRESC_W'(`CCD_PRESC_RST);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_q <= `CCD_ACC_RST;
      stat_q <= 3'b011;
      fwr_q <= '0;
      wdog_q <= '0;
      presc_q <= '0;
      done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      acc_q <= acc_d;
      stat_q <= stat_d;
      fwr_q <= fwr_d;
      wdog_q <= wdog_d;
      presc_q <= presc_d;
      done_q <= done_d;
    end
  end

  assign acc_o = acc_q;
  assign status_o = stat_q;
  assign file_wr_o = fwr_q;
  assign watchdog_counter_o = wdog_q;
  assign presc_o = presc_q;
  assign instr_done_o = done_q;
endmodule : ccd_exec
`default_nettype wire

/* File: design/ccd_pkg.sv */
// Purpose: shared types for the execution block
// Assumes: constants come from ccd_cfg.svh
// Notes: types only
package ccd_pkg;
  typedef enum logic [4:0] {
    CCD_OP_NONE = 5'b00001,
    CCD_OP_ZERO_ACC = 5'b00010,
    CCD_OP_INV = 5'b00100,
    CCD_OP_WDOG = 5'b01000,
    CCD_OP_DEC = 5'b10000
  } ccd_op_e;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } ccd_fwr_s;

  typedef struct packed {
    logic zero;
    logic wdog_expiry_flag_n;
    logic sleep_entered_flag_n;
  } ccd_stat_s;
endpackage : ccd_pkg

/* File: tb/ccd_exec_chk.sv */
// Purpose: port checks for ccd_exec
// Assumes: commit on every 4th enabled edge
// Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module ccd_exec_chk #(
  parameter int WDOG_W = 8,
  parameter int PRESC_W = 8
) (
  input wire logic sys_clk_i, // Clk
  input wire logic rst_n_i, // Rst
  input wire logic clk_en_i, // En
  input wire logic instr_valid_i, // Vld
  input wire logic [13:0] instr_i, // Op
  input wire logic [7:0] file_rdata_i, // Rd
  input wire logic presc_to_wdog_i, // Asg
  input wire logic status_set_i, // Ld
  input wire ccd_pkg::ccd_fwr_s file_wr_o, // Wr
  input wire logic [7:0] acc_o, // Acc
  input wire ccd_pkg::ccd_stat_s status_o, // St
  input wire logic [WDOG_W-1:0] watchdog_counter_o, // Wd
  input wire logic [PRESC_W-1:0] presc_o, // Ps
  input wire logic instr_done_o // Done
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic go, kk, dc, iv;
  always_comb ph_d = clk_en_i ? ph_q + 2'h1 : ph_q;
  // Reset branch holds constants only
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ph_q <= 2'h0;
    else
      ph_q <= ph_d;
  end
  assign go = clk_en_i && instr_valid_i && ph_q == 2'h3;
  assign kk = go && instr_i == 14'h0064;
  assign dc = go && instr_i[13:8] == 6'h03;
  assign iv = go && instr_i[13:8] == 6'h09;
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_k0; kk |=> watchdog_counter_o == '0; endproperty
  a_k0: assert property (p_k0) else $error("wdog");
  property p_k1; kk && presc_to_wdog_i |=> presc_o == '0; endproperty
  a_k1: assert property (p_k1) else $error("presc");
  property p_k2; kk && !status_set_i |=> status_o == {$past(status_o.zero), 2'h3}; endproperty
  a_k2: assert property (p_k2) else $error("flags");
  property p_d0; dc |=> status_o.zero == ($past(file_rdata_i) == 8'h01); endproperty
  a_d0: assert property (p_d0) else $error("dec z");
  property p_d1; dc && !instr_i[7] |=> acc_o == $past(file_rdata_i) - 8'h01 && !file_wr_o.we; endproperty
  a_d1: assert property (p_d1) else $error("dec w");
  property p_d2; dc && instr_i[7] |=> file_wr_o == {1'h1, $past(instr_i[6:0]), $past(file_rdata_i) - 8'h01}; endproperty
  a_d2: assert property (p_d2) else $error("dec f");
  property p_dn; go |=> instr_done_o ##1 !instr_done_o; endproperty
  a_dn: assert property (p_dn) else $error("done");
  property p_id; !go |=> !instr_done_o && !file_wr_o.we; endproperty
  a_id: assert property (p_id) else $error("idle");
  property p_cw; go && instr_i == 14'h0103 |=> acc_o == 8'h00 && status_o.zero; endproperty
  a_cw: assert property (p_cw) else $error("clr");
  property p_iv; iv |=> status_o.zero == ($past(file_rdata_i) == 8'hFF); endproperty
  a_iv: assert property (p_iv) else $error("inv");
  c_k: cover property (kk && presc_to_wdog_i);
  c_d: cover property (dc && instr_i[7]);
  c_i: cover property (iv);
endmodule : ccd_exec_chk
bind ccd_exec ccd_exec_chk #(.WDOG_W(WDOG_W), .PRESC_W(PRESC_W)) u_chk (.*);
`default_nettype wire

/* File: tb/clear_complement_decrement_exec_test.sv */
// Purpose: directed test of ccd_exec
// Assumes: checker bound alongside
// Notes: status is {zero, expiry_n, sleep_n}
`timescale 1ns/10ps
`default_nettype none
module clear_complement_decrement_exec_test;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic clk_en_i = 1'h1;
  logic instr_valid_i = 1'h0;
  logic presc_to_wdog_i = 1'h0;
  logic wdog_tick_i = 1'h0;
  logic status_set_i = 1'h0;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0] file_rdata_i = 8'h00;
  ccd_pkg::ccd_stat_s status_in_i = 3'h0;
  ccd_pkg::ccd_fwr_s file_wr_o;
  ccd_pkg::ccd_stat_s status_o;
  logic [6:0] file_addr_o;
  logic [7:0] acc_o, watchdog_counter_o, presc_o;
  logic instr_done_o;
  int fails = 0, n_compared = 0, cyc = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  ccd_exec dut (.*);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Valid stays up so the next op lands on the very next commit
  task automatic t(input logic [13:0] op, input logic [7:0] rd, input logic [7:0] a, input logic [15:0] w,
                   input logic z);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    instr_i <= op;
    file_rdata_i <= rd;
    instr_valid_i <= 1'h1;
    do @(negedge sys_clk_i); while (instr_done_o !== 1'h1 && ++n < 8);
    chk("done", 16'h0001, {15'h0000, instr_done_o});
    chk("addr", {9'h000, op[6:0]}, {9'h000, file_addr_o});
    chk("acc", {8'h00, a}, {8'h00, acc_o});
    chk("wr", w, w[15] ? file_wr_o : {file_wr_o.we, 15'h0000});
    chk("z", {15'h0000, z}, {15'h0000, status_o.zero});
  endtask : t
  task automatic tk(input logic p);
    @(posedge sys_clk_i);
    instr_valid_i <= 1'h0;
    presc_to_wdog_i <= p;
    repeat (3)
    begin
      @(posedge sys_clk_i) wdog_tick_i <= 1'h1;
      @(posedge sys_clk_i) wdog_tick_i <= 1'h0;
    end
    @(negedge sys_clk_i);
  endtask : tk
  always @(posedge sys_clk_i)
  begin
    if (++cyc == 3000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    t(14'h035B, 8'h5B, 8'h5A, 16'h0000, 1'h0);
    t(14'h0103, 8'h77, 8'h00, 16'h0000, 1'h1);
    t(14'h0913, 8'h13, 8'hEC, 16'h0000, 1'h0);
    t(14'h09FF, 8'hFF, 8'hEC, 16'hFF00, 1'h1);
    t(14'h03C5, 8'h01, 8'hEC, 16'hC500, 1'h1);
    t(14'h0300, 8'h00, 8'hFF, 16'h0000, 1'h0);
    t(14'h03FF, 8'h80, 8'hFF, 16'hFF7F, 1'h0);
    // Unknown opcode only pulses done, nothing else moves
    t(14'h0000, 8'h12, 8'hFF, 16'h0000, 1'h0);
    @(posedge sys_clk_i);
    instr_valid_i <= 1'h0;
    status_set_i <= 1'h1;
    status_in_i <= 3'h4;
    @(posedge sys_clk_i) status_set_i <= 1'h0;
    tk(1'h0);
    chk("wd", 16'h0003, {8'h00, watchdog_counter_o});
    t(14'h0064, 8'h00, 8'hFF, 16'h0000, 1'h1);
    chk("st", 16'h0007, {13'h0000, status_o});
    chk("wd", 16'h0000, {8'h00, watchdog_counter_o});
    tk(1'h1);
    chk("ps", 16'h0003, {8'h00, presc_o});
    t(14'h0064, 8'h00, 8'hFF, 16'h0000, 1'h1);
    chk("ps", 16'h0000, {8'h00, presc_o});
    wrap_up();
  end
endmodule : clear_complement_decrement_exec_test
`default_nettype wire
